//--- logic/rx_mon_map.svh
/*
  Register offsets, field positions, reset values and timing counts of the
  per-port video monitor register bank.
  Assumes inclusion by bare name from logic/ sources.
*/
`ifndef RX_MON_MAP_SVH
`define RX_MON_MAP_SVH

// Register offsets (byte addresses in the device register space)
`define PORT_SELECT_OFS      8'h4C
`define FRAME_LINES_UPPER    8'h73
`define FRAME_LINES_LOWER    8'h74
`define LINE_WIDTH_UPPER     8'h75
`define LINE_WIDTH_LOWER     8'h76
`define FREQ_MON_CFG         8'h77
`define SCRATCH_MSG_A        8'h78
`define SCRATCH_MSG_B        8'h79

// Frequency monitor config field positions
`define DEADBAND_MSB         7
`define DEADBAND_LSB         6
`define SETTLE_MSB           5
`define SETTLE_LSB           4
`define FLOOR_MSB            3
`define FLOOR_LSB            0

// Reset values
`define FREQ_MON_CFG_RST     8'hC5
`define SCRATCH_A_RST        8'h00
`define SCRATCH_B_RST        8'h01
`define COUNT_RST            16'h0000

// Settle times in ns, and core clock period in ns
`define CORE_CLK_NS          20
`define SETTLE0_NS           40000
`define SETTLE1_NS           80000
`define SETTLE2_NS           320000
`define SETTLE3_NS           1280000
`define SETTLE0_CYC          ((`SETTLE0_NS + `CORE_CLK_NS - 1) / `CORE_CLK_NS)
`define SETTLE1_CYC          ((`SETTLE1_NS + `CORE_CLK_NS - 1) / `CORE_CLK_NS)
`define SETTLE2_CYC          ((`SETTLE2_NS + `CORE_CLK_NS - 1) / `CORE_CLK_NS)
`define SETTLE3_CYC          ((`SETTLE3_NS + `CORE_CLK_NS - 1) / `CORE_CLK_NS)

`endif

//--- logic/rx_mon_pkg.sv
/*
  Types shared by the video monitor register bank.
  Assumes nothing beyond a SystemVerilog compiler.
*/
package rx_mon_pkg;
  // Settle time selection code
  typedef logic [1:0] settle_code_type;
  // Register byte
  typedef logic [7:0] reg_byte_type;
endpackage

//--- logic/rx_mon_freq.sv
/*
  Clock frequency monitor for one receive port: deadband-filtered
  measurement, stability timer and low-frequency flag.
  Assumes freq_meas arrives in MHz with a one-cycle valid strobe.
*/
`timescale 1ns/1ps
`include "rx_mon_map.svh"
module rx_mon_freq
  import rx_mon_pkg::*;
#(
  parameter int FREQ_W    = 8,
  parameter int SETTLE0   = `SETTLE0_CYC,
  parameter int SETTLE1   = `SETTLE1_CYC,
  parameter int SETTLE2   = `SETTLE2_CYC,
  parameter int SETTLE3   = `SETTLE3_CYC
)
(
  // Clock and reset
  input  wire logic              core_clk,
  input  wire logic              nrst,
  // Configuration
  input  wire logic [1:0]        freq_deadband,
  input  wire settle_code_type   freq_settle_time,
  input  wire logic [3:0]        freq_floor,
  // Measurement
  input  wire logic              freq_valid,
  input  wire logic [FREQ_W-1:0] freq_meas,
  // Results
  output logic [FREQ_W-1:0]      freq_held_ff,
  output logic                   freq_stable_ff,
  output logic                   freq_slow_ff
);
  localparam int TW = 21;

  logic [FREQ_W-1:0] nxt_freq_held;    // Captured frequency
  logic [TW-1:0]     timer_ff;         // Cycles since last capture, stops at the settle limit
  logic [TW-1:0]     nxt_timer;
  logic              nxt_stable;
  logic              nxt_slow;
  logic [TW-1:0]     settle_lim;       // Selected settle time in cycles
  logic [FREQ_W-1:0] diff;             // Distance to captured value

  // Next-state computation
  always_comb
  begin
    unique case (freq_settle_time)
      2'h0: settle_lim = TW'(SETTLE0);
      2'h1: settle_lim = TW'(SETTLE1);
      2'h2: settle_lim = TW'(SETTLE2);
      2'h3: settle_lim = TW'(SETTLE3);
    endcase
    diff = (freq_meas > freq_held_ff) ? freq_meas - freq_held_ff
                                      : freq_held_ff - freq_meas;
    nxt_freq_held = freq_held_ff;
    nxt_timer     = timer_ff;
    nxt_slow      = freq_slow_ff;
    // Small jitter inside the deadband does not disturb the timer
    if (freq_valid && diff > FREQ_W'(freq_deadband))
    begin
      nxt_freq_held = freq_meas;
      nxt_timer     = '0;
    end
    else if (timer_ff < settle_lim)
    begin
      nxt_timer = timer_ff + TW'(1);
    end
    // Stable once the band held for the whole settle time
    nxt_stable = (nxt_timer >= settle_lim);
    if (freq_valid)
    begin
      nxt_slow = (freq_meas < FREQ_W'(freq_floor));
    end
  end

  // Registers
  always_ff @(posedge core_clk)
  begin
    if (!nrst)
    begin
      freq_held_ff   <= '0;
      timer_ff       <= '0;
      freq_stable_ff <= 1'b0;
      freq_slow_ff   <= 1'b0;
    end
    else
    begin
      freq_held_ff   <= nxt_freq_held;
      timer_ff       <= nxt_timer;
      freq_stable_ff <= nxt_stable;
      freq_slow_ff   <= nxt_slow;
    end
  end
endmodule

//--- logic/rx_port_video_monitor_regs.sv
/*
  Per-receive-port video monitor and scratch registers, two ports.
  Assumes a byte register port driven by the I2C target logic with one-cycle
  read and write strobes, and video/frequency inputs synchronous to core_clk.
*/
// Behaviour
// - Report last frame line count, two bytes
// - Freeze line count while its irq enabled
// - Upper count read latches lower byte
// - Report last line length, two bytes
// - Freeze line length while its irq enabled
// - Upper length read latches lower byte
// - Capture frequency only beyond deadband
// - Stable after selected settle time
// - Flag clock below floor as slow
// - Two read/write mailbox bytes, resets 00/01
// - Port select steers per-port access
`timescale 1ns/1ps
`include "rx_mon_map.svh"
module rx_port_video_monitor_regs
  import rx_mon_pkg::*;
#(
  parameter int PORTS  = 2,
  parameter int FREQ_W = 8
)
(
  // Clock and reset
  input  wire logic                    core_clk,
  input  wire logic                    nrst,
  // Register port
  input  wire logic [7:0]              reg_addr,
  input  wire logic [7:0]              reg_wdata,
  input  wire logic                    reg_wr,
  input  wire logic                    reg_rd,
  output logic [7:0]                   reg_rdata_ff,
  // Port select and change-interrupt enables, one bit per port
  input  wire logic [PORTS-1:0]        port_sel,
  input  wire logic [PORTS-1:0]        frame_lines_change_irq_en,
  input  wire logic [PORTS-1:0]        line_width_change_irq_en,
  // Video measurements per port
  input  wire logic [PORTS-1:0]        frame_done,
  input  wire logic [PORTS*16-1:0]     frame_lines_meas,
  input  wire logic [PORTS-1:0]        line_done,
  input  wire logic [PORTS*16-1:0]     line_width_meas,
  // Frequency measurements per port
  input  wire logic [PORTS-1:0]        freq_valid,
  input  wire logic [PORTS*FREQ_W-1:0] freq_meas,
  // Frequency monitor results per port
  output logic [PORTS*FREQ_W-1:0]      freq_held_ff,
  output logic [PORTS-1:0]             freq_stable_ff,
  output logic [PORTS-1:0]             freq_slow_ff
);
  // Per-port state
  logic [15:0] lines_ff     [PORTS];   // Reported frame line count
  logic [15:0] width_ff     [PORTS];   // Reported line length
  logic [7:0]  lines_lo_ff  [PORTS];   // Lower count byte shadow
  logic [7:0]  width_lo_ff  [PORTS];   // Lower length byte shadow
  logic        lines_frz_ff [PORTS];   // Count is frozen
  logic        width_frz_ff [PORTS];   // Length is frozen
  reg_byte_type cfg_ff      [PORTS];   // Frequency monitor config
  reg_byte_type msg_a_ff    [PORTS];   // Mailbox byte A
  reg_byte_type msg_b_ff    [PORTS];   // Mailbox byte B
  logic [15:0] nxt_lines    [PORTS];
  logic [15:0] nxt_width    [PORTS];
  logic [7:0]  nxt_lines_lo [PORTS];
  logic [7:0]  nxt_width_lo [PORTS];
  logic        nxt_lines_frz[PORTS];
  logic        nxt_width_frz[PORTS];
  reg_byte_type nxt_cfg     [PORTS];
  reg_byte_type nxt_msg_a   [PORTS];
  reg_byte_type nxt_msg_b   [PORTS];
  logic [7:0]  nxt_rdata;
  logic [PORTS-1:0] rd_hit;            // Read reaches this port
  logic [PORTS-1:0] wr_hit;            // Write reaches this port

  // Per-port next-state: capture, freeze and register writes
  always_comb
  begin
    for (int p = 0; p < PORTS; p++)
    begin
      rd_hit[p] = reg_rd && port_sel[p];
      wr_hit[p] = reg_wr && port_sel[p];
      nxt_lines[p]     = lines_ff[p];
      nxt_width[p]     = width_ff[p];
      nxt_lines_lo[p]  = lines_lo_ff[p];
      nxt_width_lo[p]  = width_lo_ff[p];
      nxt_lines_frz[p] = lines_frz_ff[p];
      nxt_width_frz[p] = width_frz_ff[p];
      nxt_cfg[p]       = cfg_ff[p];
      nxt_msg_a[p]     = msg_a_ff[p];
      nxt_msg_b[p]     = msg_b_ff[p];
      // Lower byte read ends a freeze; a new value that same cycle is lost
      // to the old freeze so software never sees a torn update
      if (rd_hit[p] && reg_addr == `FRAME_LINES_LOWER)
      begin
        nxt_lines_frz[p] = 1'b0;
      end
      if (rd_hit[p] && reg_addr == `LINE_WIDTH_LOWER)
      begin
        nxt_width_frz[p] = 1'b0;
      end
      // New frame count taken unless frozen
      if (frame_done[p] && !lines_frz_ff[p])
      begin
        nxt_lines[p] = frame_lines_meas[p*16 +: 16];
        nxt_lines_frz[p] = frame_lines_change_irq_en[p];
      end
      if (!frame_lines_change_irq_en[p])
      begin
        nxt_lines_frz[p] = 1'b0;
      end
      // Each completed line overwrites unless frozen, so the frame's last line remains
      if (line_done[p] && !width_frz_ff[p])
      begin
        nxt_width[p] = line_width_meas[p*16 +: 16];
        nxt_width_frz[p] = line_width_change_irq_en[p];
      end
      if (!line_width_change_irq_en[p])
      begin
        nxt_width_frz[p] = 1'b0;
      end
      // Upper byte read snapshots the lower byte
      if (rd_hit[p] && reg_addr == `FRAME_LINES_UPPER)
      begin
        nxt_lines_lo[p] = lines_ff[p][7:0];
      end
      if (rd_hit[p] && reg_addr == `LINE_WIDTH_UPPER)
      begin
        nxt_width_lo[p] = width_ff[p][7:0];
      end
      // Writable registers
      if (wr_hit[p])
      begin
        unique case (reg_addr)
          `FREQ_MON_CFG:  nxt_cfg[p]   = reg_wdata;
          `SCRATCH_MSG_A: nxt_msg_a[p] = reg_wdata;
          `SCRATCH_MSG_B: nxt_msg_b[p] = reg_wdata;
          default:        ;
        endcase
      end
    end
  end

  // Read data from the lowest selected port; unmapped reads give zero
  always_comb
  begin
    nxt_rdata = reg_rdata_ff;
    if (reg_rd)
    begin
      nxt_rdata = 8'h00;
      for (int p = PORTS - 1; p >= 0; p--)
      begin
        if (port_sel[p])
        begin
          unique case (reg_addr)
            `FRAME_LINES_UPPER: nxt_rdata = lines_ff[p][15:8];
            `FRAME_LINES_LOWER: nxt_rdata = lines_lo_ff[p];
            `LINE_WIDTH_UPPER:  nxt_rdata = width_ff[p][15:8];
            `LINE_WIDTH_LOWER:  nxt_rdata = width_lo_ff[p];
            `FREQ_MON_CFG:      nxt_rdata = cfg_ff[p];
            `SCRATCH_MSG_A:     nxt_rdata = msg_a_ff[p];
            `SCRATCH_MSG_B:     nxt_rdata = msg_b_ff[p];
            default:            nxt_rdata = 8'h00;
          endcase
        end
      end
    end
  end

  // Registers
  always_ff @(posedge core_clk)
  begin
    if (!nrst)
    begin
      reg_rdata_ff <= 8'h00;
      for (int p = 0; p < PORTS; p++)
      begin
        lines_ff[p]     <= `COUNT_RST;
        width_ff[p]     <= `COUNT_RST;
        lines_lo_ff[p]  <= 8'h00;
        width_lo_ff[p]  <= 8'h00;
        lines_frz_ff[p] <= 1'b0;
        width_frz_ff[p] <= 1'b0;
        cfg_ff[p]       <= `FREQ_MON_CFG_RST;
        msg_a_ff[p]     <= `SCRATCH_A_RST;
        msg_b_ff[p]     <= `SCRATCH_B_RST;
      end
    end
    else
    begin
      reg_rdata_ff <= nxt_rdata;
      for (int p = 0; p < PORTS; p++)
      begin
        lines_ff[p]     <= nxt_lines[p];
        width_ff[p]     <= nxt_width[p];
        lines_lo_ff[p]  <= nxt_lines_lo[p];
        width_lo_ff[p]  <= nxt_width_lo[p];
        lines_frz_ff[p] <= nxt_lines_frz[p];
        width_frz_ff[p] <= nxt_width_frz[p];
        cfg_ff[p]       <= nxt_cfg[p];
        msg_a_ff[p]     <= nxt_msg_a[p];
        msg_b_ff[p]     <= nxt_msg_b[p];
      end
    end
  end

  // One frequency monitor per port
  for (genvar g = 0; g < PORTS; g++)
  begin : g_freq
    rx_mon_freq #(
      .FREQ_W (FREQ_W)
    ) u_freq (
      .core_clk         (core_clk),
      .nrst             (nrst),
      .freq_deadband    (cfg_ff[g][`DEADBAND_MSB:`DEADBAND_LSB]),
      .freq_settle_time (cfg_ff[g][`SETTLE_MSB:`SETTLE_LSB]),
      .freq_floor       (cfg_ff[g][`FLOOR_MSB:`FLOOR_LSB]),
      .freq_valid       (freq_valid[g]),
      .freq_meas        (freq_meas[g*FREQ_W +: FREQ_W]),
      .freq_held_ff     (freq_held_ff[g*FREQ_W +: FREQ_W]),
      .freq_stable_ff   (freq_stable_ff[g]),
      .freq_slow_ff     (freq_slow_ff[g])
    );
  end
endmodule

//--- dv/rx_mon_asserts.sv
/*
  Port-level checker for the video monitor register bank.
  Assumes a bind onto the top module, PORTS of 2.
*/
`timescale 1ns/1ps
module rx_mon_asserts
  import rx_mon_pkg::*;
#(
  parameter int PORTS  = 2,
  parameter int FREQ_W = 8
)
(
  // Clock and reset
  input wire logic                    core_clk,
  input wire logic                    nrst,
  // Register port
  input wire logic [7:0]              reg_addr,
  input wire logic [7:0]              reg_wdata,
  input wire logic                    reg_wr,
  input wire logic                    reg_rd,
  input wire logic [7:0]              reg_rdata_ff,
  input wire logic [PORTS-1:0]        port_sel,
  // Frequency monitor
  input wire logic [PORTS-1:0]        freq_valid,
  input wire logic [PORTS*FREQ_W-1:0] freq_held_ff,
  input wire logic [PORTS-1:0]        freq_stable_ff
);
  // One domain, so clock and reset are given once
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!nrst);

  // Read data stands until the next read
  property p_rd_hold;
    !reg_rd |=> $stable(reg_rdata_ff);
  endproperty
  a_rd_hold: assert property (p_rd_hold)
    else $error("read data moved without a read");

  // Unmapped offsets read as zero
  property p_unmapped;
    reg_rd && (reg_addr < 8'h73 || reg_addr > 8'h79) |=> reg_rdata_ff == 8'h00;
  endproperty
  a_unmapped: assert property (p_unmapped)
    else $error("unmapped read not zero");

  // No port selected reads as zero
  property p_no_port;
    reg_rd && port_sel == '0 |=> reg_rdata_ff == 8'h00;
  endproperty
  a_no_port: assert property (p_no_port)
    else $error("read with no port selected not zero");

  // Mailbox write then read returns the written byte
  property p_mbox;
    reg_wr && reg_addr == 8'h78 && port_sel != '0
      ##1 reg_rd && reg_addr == 8'h78 && $stable(port_sel)
      |=> reg_rdata_ff == $past(reg_wdata, 2);
  endproperty
  a_mbox: assert property (p_mbox)
    else $error("mailbox readback differs");

  // Held frequency moves only after a measurement
  property p_held0;
    !$stable(freq_held_ff[FREQ_W-1:0]) |-> $past(freq_valid[0]);
  endproperty
  a_held0: assert property (p_held0)
    else $error("port 0 held frequency moved alone");

  property p_held1;
    !$stable(freq_held_ff[2*FREQ_W-1:FREQ_W]) |-> $past(freq_valid[1]);
  endproperty
  a_held1: assert property (p_held1)
    else $error("port 1 held frequency moved alone");

  // A new capture restarts the settle time
  property p_restart;
    !$stable(freq_held_ff[FREQ_W-1:0]) |=> !freq_stable_ff[0];
  endproperty
  a_restart: assert property (p_restart)
    else $error("stable kept across a new capture");

  // Stable only rises after a quiet stretch
  property p_settle;
    $rose(freq_stable_ff[0])
      |-> $past(freq_held_ff[FREQ_W-1:0], 8) == freq_held_ff[FREQ_W-1:0];
  endproperty
  a_settle: assert property (p_settle)
    else $error("stable rose right after a capture");

  // Main scenarios
  c_upper: cover property (reg_rd && reg_addr == 8'h73);
  c_stable: cover property ($rose(freq_stable_ff[0]));
  c_mbox: cover property (reg_wr && reg_addr == 8'h78);
endmodule

//--- dv/rx_video_src.sv
/*
  Far-side model: remote video source feeding line, width and
  frequency measurements. Assumes calls from the bench at negedge.
*/
`timescale 1ns/1ps
module rx_video_src
(
  // Clock
  input wire logic   core_clk,
  // Measurements, two ports
  output logic [1:0]  frame_done,
  output logic [31:0] frame_lines_meas,
  output logic [1:0]  line_done,
  output logic [31:0] line_width_meas,
  output logic [1:0]  freq_valid,
  output logic [15:0] freq_meas
);
  initial
  begin
    frame_done = 2'h0;
    line_done = 2'h0;
    freq_valid = 2'h0;
    frame_lines_meas = 32'h0;
    line_width_meas = 32'h0;
    freq_meas = 16'h0;
  end

  // One strobe: k 0 frame end, 1 line end, 2 frequency
  task automatic pulse(input int k, input int p, input logic [15:0] v);
    @(negedge core_clk);
    frame_done[p] = (k == 0);
    line_done[p] = (k == 1);
    freq_valid[p] = (k == 2);
    frame_lines_meas[16*p+:16] = v;
    line_width_meas[16*p+:16] = v;
    freq_meas[8*p+:8] = v[7:0];
    @(negedge core_clk);
    frame_done[p] = 1'b0;
    line_done[p] = 1'b0;
    freq_valid[p] = 1'b0;
    // Values are stale once the strobe drops, so show garbage
    frame_lines_meas[16*p+:16] = ~v;
    line_width_meas[16*p+:16] = ~v;
    freq_meas[8*p+:8] = ~v[7:0];
  endtask
endmodule

//--- dv/tb.sv
/*
  Self-checking bench for the video monitor register bank.
  Assumes the checker and the source model compiled first.
*/
`timescale 1ns/1ps
`define CHK(nm, e, g) begin cmp_count++; if ((g) !== (e)) begin n_fail++; \
  $display("CHECK FAILED %s exp %0h got %0h", nm, e, g); end end
module tb;
  // Bench-driven inputs, all set at time zero
  logic        core_clk = 1'b0;
  logic        nrst = 1'b0;
  logic [7:0]  reg_addr = 8'h00;
  logic [7:0]  reg_wdata = 8'h00;
  logic        reg_wr = 1'b0;
  logic        reg_rd = 1'b0;
  logic [1:0]  port_sel = 2'b01;
  logic [1:0]  fl_en = 2'b00;
  logic [1:0]  lw_en = 2'b00;
  // Source model and design outputs
  logic [1:0]  frame_done, line_done, freq_valid;
  logic [31:0] frame_lines_meas, line_width_meas;
  logic [15:0] freq_meas, freq_held_ff;
  logic [1:0]  freq_stable_ff, freq_slow_ff;
  logic [7:0]  reg_rdata_ff;
  int          n_fail = 0;
  int          cmp_count = 0;
  int          cyc = 0;

  always #10 core_clk = ~core_clk;

  rx_port_video_monitor_regs u_dut (.core_clk, .nrst, .reg_addr,
    .reg_wdata, .reg_wr, .reg_rd, .reg_rdata_ff, .port_sel,
    .frame_lines_change_irq_en(fl_en), .line_width_change_irq_en(lw_en),
    .frame_done, .frame_lines_meas, .line_done, .line_width_meas,
    .freq_valid, .freq_meas, .freq_held_ff, .freq_stable_ff, .freq_slow_ff);
  rx_video_src u_src (.core_clk, .frame_done, .frame_lines_meas,
    .line_done, .line_width_meas, .freq_valid, .freq_meas);

  // Register read, checked once the answer has landed
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    @(negedge core_clk);
    reg_addr = a;
    reg_rd = 1'b1;
    @(negedge core_clk);
    reg_rd = 1'b0;
    `CHK("rdata", e, reg_rdata_ff)
  endtask

  // Write, optionally followed at once by a read of the same place
  task automatic wr(input logic [7:0] a, input logic [7:0] d, input bit rb);
    @(negedge core_clk);
    reg_addr = a;
    reg_wdata = d;
    reg_wr = 1'b1;
    @(negedge core_clk);
    reg_wr = 1'b0;
    reg_rd = rb;
    if (rb)
    begin
      @(negedge core_clk);
      reg_rd = 1'b0;
      `CHK("readback", d, reg_rdata_ff)
    end
  endtask

  task automatic t_reset;
    rd(8'h73, 8'h00);
    rd(8'h74, 8'h00);
    rd(8'h75, 8'h00);
    rd(8'h76, 8'h00);
    rd(8'h77, 8'hC5);
    rd(8'h78, 8'h00);
    rd(8'h79, 8'h01);
    wr(8'h74, 8'hFF, 1'b0);
    rd(8'h74, 8'h00);
    rd(8'h7A, 8'h00);
  endtask

  // Without freeze every end updates; the last one is reported
  task automatic t_last;
    u_src.pulse(0, 0, 16'h1234);
    u_src.pulse(0, 0, 16'h0456);
    rd(8'h73, 8'h04);
    rd(8'h74, 8'h56);
    u_src.pulse(1, 0, 16'h0100);
    u_src.pulse(1, 0, 16'h0280);
    rd(8'h75, 8'h02);
    rd(8'h76, 8'h80);
  endtask

  // Freeze, coherent pair read, release; k 0 line count, 1 width
  task automatic t_freeze(input int k);
    logic [7:0] a;
    a = 8'h73 + 8'(2 * k);
    fl_en[0] = (k == 0);
    lw_en[0] = (k == 1);
    u_src.pulse(k, 0, 16'h0ABC);
    u_src.pulse(k, 0, 16'h0DEF);
    rd(a, 8'h0A);
    u_src.pulse(k, 0, 16'h0111);
    rd(a + 8'h01, 8'hBC);
    u_src.pulse(k, 0, 16'h0222);
    rd(a, 8'h02);
    rd(a + 8'h01, 8'h22);
    fl_en = 2'b00;
    lw_en = 2'b00;
  endtask

  // Per-port copies steered by the port select
  task automatic t_port;
    wr(8'h78, 8'hA5, 1'b1);
    port_sel = 2'b10;
    wr(8'h78, 8'h3C, 1'b1);
    wr(8'h79, 8'h5A, 1'b1);
    port_sel = 2'b01;
    rd(8'h78, 8'hA5);
    rd(8'h79, 8'h01);
    u_src.pulse(0, 1, 16'h0777);
    rd(8'h73, 8'h02);
    port_sel = 2'b10;
    rd(8'h73, 8'h07);
    rd(8'h74, 8'h77);
    port_sel = 2'b00;
    rd(8'h78, 8'h00);
    port_sel = 2'b01;
    // Port 1 frequency monitor works on its own measurement
    u_src.pulse(2, 1, 16'd4);
    `CHK("held1", 8'd4, freq_held_ff[15:8])
    `CHK("slow1", 1'b1, freq_slow_ff[1])
  endtask

  // Deadband, floor and settle time on port 0
  task automatic t_freq;
    u_src.pulse(2, 0, 16'd20);
    `CHK("held", 8'd20, freq_held_ff[7:0])
    u_src.pulse(2, 0, 16'd23);
    `CHK("held", 8'd20, freq_held_ff[7:0])
    u_src.pulse(2, 0, 16'd24);
    `CHK("held", 8'd24, freq_held_ff[7:0])
    u_src.pulse(2, 0, 16'd4);
    `CHK("slow", 1'b1, freq_slow_ff[0])
    wr(8'h77, 8'h07, 1'b1);
    u_src.pulse(2, 0, 16'd6);
    `CHK("slow", 1'b1, freq_slow_ff[0])
    u_src.pulse(2, 0, 16'd7);
    `CHK("held", 8'd7, freq_held_ff[7:0])
    `CHK("slow", 1'b0, freq_slow_ff[0])
    repeat (1900) @(negedge core_clk);
    `CHK("stable", 1'b0, freq_stable_ff[0])
    repeat (200) @(negedge core_clk);
    `CHK("stable", 1'b1, freq_stable_ff[0])
  endtask

  // Settle codes 01 and 10 timed side by side on the two ports; code 11 only checked still unsettled
  task automatic t_settle;
    wr(8'h77, 8'h27, 1'b1);
    port_sel = 2'b10;
    wr(8'h77, 8'h15, 1'b1);
    u_src.pulse(2, 0, 16'd8);
    u_src.pulse(2, 1, 16'd9);
    repeat (3900) @(negedge core_clk);
    `CHK("stable1", 1'b0, freq_stable_ff[1])
    repeat (200) @(negedge core_clk);
    `CHK("stable1", 1'b1, freq_stable_ff[1])
    wr(8'h77, 8'h35, 1'b0);
    u_src.pulse(2, 1, 16'd10);
    repeat (11790) @(negedge core_clk);
    `CHK("stable0", 1'b0, freq_stable_ff[0])
    repeat (200) @(negedge core_clk);
    `CHK("stable0", 1'b1, freq_stable_ff[0])
    `CHK("stable1", 1'b0, freq_stable_ff[1])
    port_sel = 2'b01;
  endtask

  task automatic results;
    $display("comparisons %0d mismatches %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  // Hang guard, above the roughly 18500 cycles the scenarios need
  always @(posedge core_clk)
  begin
    cyc++;
    if (cyc == 25000)
    begin
      n_fail++;
      results();
    end
  end

  initial
  begin
    repeat (4) @(negedge core_clk);
    nrst = 1'b1;
    t_reset();
    t_last();
    t_freeze(0);
    t_freeze(1);
    t_port();
    t_freq();
    t_settle();
    results();
  end
endmodule

bind rx_port_video_monitor_regs rx_mon_asserts #(.PORTS(PORTS),
  .FREQ_W(FREQ_W)) u_chk (.core_clk, .nrst, .reg_addr, .reg_wdata,
  .reg_wr, .reg_rd, .reg_rdata_ff, .port_sel, .freq_valid,
  .freq_held_ff, .freq_stable_ff);
